// >>> common/see_map.vh
// Constants for the serial EEPROM command engine
`ifndef SEE_MAP_VH
`define SEE_MAP_VH
`define SEE_OP_WRITE_ENABLE 8'h06
`define SEE_OP_WRITE_DISABLE 8'h04
`define SEE_OP_STATUS_READ 8'h05
`define SEE_OP_STATUS_WRITE 8'h01
`define SEE_OP_MEM_READ 8'h03
`define SEE_OP_MEM_WRITE 8'h02
`define SEE_SR_PIN_ENABLE 7
`define SEE_SR_PAGE_SELECT 6
`define SEE_SR_PAGE_LOCK 4
`define SEE_SR_PROTECT_HIGH 3
`define SEE_SR_PROTECT_LOW 2
`define SEE_SR_RESET 8'h00
`define SEE_ADDR_BITS 17
`define SEE_PAGE_BYTES 256
`define SEE_CLK_MHZ 200
`define SEE_WRITE_TIME_US 5000
`define SEE_WRITE_CYCLES (`SEE_WRITE_TIME_US * `SEE_CLK_MHZ)
`endif

// >>> verilog/see_engine.v
// Serial EEPROM command engine sampled on the system clock
`timescale 1ns/100ps
`include "see_map.vh"

module see_engine
#(
  parameter [19:0] WRITE_CYCLES = `SEE_WRITE_CYCLES
)
(
  // System
  input wire SYS_CLK,
  input wire RST,
  // Serial link pins
  input wire CS_N,
  input wire SCK,
  input wire SI,
  input wire HOLD_N,
  input wire WP_N,
  output wire SO,
  output wire SO_OE_N,
  // Status view
  output wire [7:0] STATUS
);

  localparam [6:0] ST_OPC = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_WDATA = 7'h04;
  localparam [6:0] ST_RDATA = 7'h08;
  localparam [6:0] ST_SRD = 7'h10;
  localparam [6:0] ST_SWR = 7'h20;
  localparam [6:0] ST_IGNORE = 7'h40;

  // Pin synchronisers and edge history
  reg cs_m, cs_s, cs_p;
  reg sck_m, sck_s, sck_p;
  reg si_m, si_s;
  reg hold_m, hold_s;
  reg wp_m, wp_s, wp_p;

  // Session state
  reg [6:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [1:0] acnt_q;
  reg [15:0] addr_q;
  reg is_read_q;
  reg [16:0] rd_q;
  reg [8:0] page_q;
  reg [7:0] idx_q;
  reg [255:0] mask_q;
  reg got_q;
  reg wen_pend_q;
  reg abort_q;
  reg [7:0] sr_new_q;
  reg [7:0] out_q;
  reg so_q;
  reg drv_q;
  reg oe_n_q;
  reg [7:0] stat_q;

  // Status bits and write cycle
  reg busy_q;
  reg wel_q;
  reg protect_pin_enable_q;
  reg idsel_q;
  reg lock_q;
  reg [1:0] bp_q;
  reg [19:0] wc_q;
  reg wid_q;
  reg wsr_q;

  // Storage
  reg [7:0] mem [0:131071];
  reg [7:0] idpg [0:255];
  reg [7:0] pbuf [0:255];

  // Block-protect decode of an array address
  function prot;
    input [16:0] a;
    input [1:0] bp;
    begin
      case (bp)
        2'b01: prot = a[16] & a[15];
        2'b10: prot = a[16];
        2'b11: prot = 1'b1;
        default: prot = 1'b0;
      endcase
    end
  endfunction

  wire sck_rise = sck_s & ~sck_p & ~cs_s & hold_s;
  wire sck_fall = ~sck_s & sck_p & ~cs_s & hold_s;
  wire cs_rise = cs_s & ~cs_p;
  wire wp_fall = ~wp_s & wp_p;
  wire [7:0] rx_byte = {sh_q[6:0], si_s};
  wire byte_done = sck_rise & (bit_q == 3'd7);
  wire [7:0] status = {protect_pin_enable_q, idsel_q, 1'b0, lock_q, bp_q, wel_q, busy_q};

  wire [16:0] addr_full = {addr_q[8:0], rx_byte};
  wire [16:0] rd_sel = (st_q == ST_ADDR) ? addr_full : rd_q;
  wire [7:0] rd_data = idsel_q ? idpg[rd_sel[7:0]] : mem[rd_sel];
  // id page counts in low byte
  wire [16:0] rd_next = idsel_q ? {rd_sel[16:8], rd_sel[7:0] + 8'h01} : rd_sel + 17'h00001;

  wire buf_we = byte_done & (st_q == ST_WDATA);
  wire commit_we = busy_q & ~wsr_q & ~(|wc_q[19:8]) & mask_q[wc_q[7:0]];
  // Whole-byte ending, partial bytes discard
  wire clean_end = got_q & (bit_q == 3'd0);
  wire hw_lock = protect_pin_enable_q & ~wp_s;

  assign SO = so_q;
  assign SO_OE_N = oe_n_q;
  assign STATUS = stat_q;

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_p <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      si_m <= 1'b0;
      si_s <= 1'b0;
      hold_m <= 1'b1;
      hold_s <= 1'b1;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
      wp_p <= 1'b1;
    end
    else
    begin
      cs_m <= CS_N;
      cs_s <= cs_m;
      cs_p <= cs_s;
      sck_m <= SCK;
      sck_s <= sck_m;
      sck_p <= sck_s;
      si_m <= SI;
      si_s <= si_m;
      hold_m <= HOLD_N;
      hold_s <= hold_m;
      wp_m <= WP_N;
      wp_s <= wp_m;
      wp_p <= wp_s;
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_q <= ST_OPC;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      acnt_q <= 2'd0;
      addr_q <= 16'h0000;
      is_read_q <= 1'b0;
      rd_q <= 17'h00000;
      page_q <= 9'h000;
      idx_q <= 8'h00;
      mask_q <= {256{1'b0}};
      got_q <= 1'b0;
      wen_pend_q <= 1'b0;
      abort_q <= 1'b0;
      sr_new_q <= 8'h00;
      out_q <= 8'h00;
      so_q <= 1'b0;
      drv_q <= 1'b0;
      oe_n_q <= 1'b1;
      stat_q <= `SEE_SR_RESET;
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      protect_pin_enable_q <= 1'b0;
      idsel_q <= 1'b0;
      lock_q <= 1'b0;
      bp_q <= 2'b00;
      wc_q <= 20'h00000;
      wid_q <= 1'b0;
      wsr_q <= 1'b0;
    end
    else
    begin
      stat_q <= status;
      oe_n_q <= ~(drv_q & hold_s & ~cs_s);
      if (busy_q)
      begin
        wc_q <= wc_q + 20'h00001;
        if (wc_q == WRITE_CYCLES - 20'h00001)
        begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
        end
      end
      if (cs_rise)
      begin
        if (wen_pend_q && bit_q == 3'd0)
          wel_q <= 1'b1;
        // start only on clean write end
        if (st_q == ST_WDATA && clean_end && wel_q && !busy_q)
        begin
          if (idsel_q)
          begin
            if (!lock_q && !prot({9'h000, idx_q}, bp_q) && bp_q != 2'b11)
            begin
              busy_q <= 1'b1;
              wc_q <= 20'h00000;
              wid_q <= 1'b1;
              wsr_q <= 1'b0;
            end
          end
          else if (!prot({page_q, 8'h00}, bp_q))
          begin
            busy_q <= 1'b1;
            wc_q <= 20'h00000;
            wid_q <= 1'b0;
            wsr_q <= 1'b0;
          end
        end
        if (st_q == ST_SWR && clean_end && wel_q && !busy_q && !abort_q && !hw_lock)
        begin
          // only bits 7, 6, 4, 3, 2 change
          protect_pin_enable_q <= sr_new_q[`SEE_SR_PIN_ENABLE];
          bp_q <= {sr_new_q[`SEE_SR_PROTECT_HIGH], sr_new_q[`SEE_SR_PROTECT_LOW]};
          // Select and lock together leave both unchanged; lock never clears
          if (!(sr_new_q[`SEE_SR_PAGE_SELECT] && sr_new_q[`SEE_SR_PAGE_LOCK]))
          begin
            idsel_q <= sr_new_q[`SEE_SR_PAGE_SELECT];
            lock_q <= lock_q | sr_new_q[`SEE_SR_PAGE_LOCK];
          end
          busy_q <= 1'b1;
          wc_q <= 20'h00000;
          wsr_q <= 1'b1;
        end
        // Page select falls back after a read or write
        if (st_q == ST_RDATA || (st_q == ST_WDATA && got_q))
          idsel_q <= 1'b0;
      end
      if (cs_s)
      begin
        st_q <= ST_OPC;
        bit_q <= 3'd0;
        acnt_q <= 2'd0;
        got_q <= 1'b0;
        wen_pend_q <= 1'b0;
        abort_q <= 1'b0;
        drv_q <= 1'b0;
      end
      else
      begin
        if (wp_fall && st_q == ST_SWR)
          abort_q <= 1'b1;
        if (sck_rise)
        begin
          bit_q <= bit_q + 3'd1;
          sh_q <= rx_byte;
          // Extra clocks after the opcode spoil the enable
          wen_pend_q <= 1'b0;
        end
        if (byte_done)
        begin
          case (st_q)
            ST_OPC:
            begin
              if (busy_q && rx_byte != `SEE_OP_STATUS_READ)
                st_q <= ST_IGNORE;
              else
              begin
                case (rx_byte)
                  `SEE_OP_WRITE_ENABLE:
                  begin
                    wen_pend_q <= 1'b1;
                    st_q <= ST_IGNORE;
                  end
                  `SEE_OP_WRITE_DISABLE:
                  begin
                    wel_q <= 1'b0;
                    st_q <= ST_IGNORE;
                  end
                  `SEE_OP_STATUS_READ:
                  begin
                    out_q <= status;
                    st_q <= ST_SRD;
                  end
                  `SEE_OP_STATUS_WRITE:
                    st_q <= ST_SWR;
                  `SEE_OP_MEM_READ:
                  begin
                    is_read_q <= 1'b1;
                    st_q <= ST_ADDR;
                  end
                  `SEE_OP_MEM_WRITE:
                  begin
                    is_read_q <= 1'b0;
                    mask_q <= {256{1'b0}};
                    st_q <= ST_ADDR;
                  end
                  default:
                    st_q <= ST_IGNORE;
                endcase
              end
            end
            ST_ADDR:
            begin
              addr_q <= {addr_q[7:0], rx_byte};
              acnt_q <= acnt_q + 2'd1;
              if (acnt_q == 2'd2)
              begin
                if (is_read_q)
                begin
                  // data right after last address bit
                  out_q <= rd_data;
                  rd_q <= rd_next;
                  st_q <= ST_RDATA;
                end
                else
                begin
                  page_q <= addr_full[16:8];
                  idx_q <= addr_full[7:0];
                  st_q <= ST_WDATA;
                end
              end
            end
            ST_WDATA:
            begin
              got_q <= 1'b1;
              idx_q <= idx_q + 8'h01;
              mask_q[idx_q] <= 1'b1;
            end
            ST_RDATA:
            begin
              out_q <= rd_data;
              rd_q <= rd_next;
            end
            ST_SRD:
              out_q <= status;
            ST_SWR:
            begin
              got_q <= 1'b1;
              sr_new_q <= rx_byte;
            end
            default:
              st_q <= ST_IGNORE;
          endcase
        end
        if (sck_fall && (st_q == ST_RDATA || st_q == ST_SRD))
        begin
          so_q <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
          drv_q <= 1'b1;
        end
      end
    end
  end

  // Arrays carry no reset; contents survive a reset like the cells would
  always @(posedge SYS_CLK)
  begin
    if (buf_we)
      pbuf[idx_q] <= rx_byte;
    if (commit_we && !wid_q)
      mem[{page_q, wc_q[7:0]}] <= pbuf[wc_q[7:0]];
    if (commit_we && wid_q)
      idpg[wc_q[7:0]] <= pbuf[wc_q[7:0]];
  end

endmodule // see_engine

// >>> tb/see_engine_sva.sv
// Pin-level assertions for the serial EEPROM engine
`timescale 1ns/100ps
module see_engine_sva
#(
  parameter [19:0] WRITE_CYCLES = 20'h4b0
)
(
  // System
  input wire SYS_CLK,
  input wire RST,
  // Serial link pins
  input wire CS_N,
  input wire HOLD_N,
  input wire WP_N,
  input wire SO_OE_N,
  // Status view
  input wire [7:0] STATUS
);
  logic [19:0] busy_q;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // Busy stretch length, compared at its end
  always @(posedge SYS_CLK or posedge RST)
    if (RST)
      busy_q <= 20'h0;
    else
      busy_q <= STATUS[0] ? busy_q + 20'h1 : 20'h0;
  cs_float_a: assert property ($rose(CS_N) |-> ##[1:6] SO_OE_N)
    else $error("output driven after deselect");
  hold_float_a: assert property (!HOLD_N [*6] |-> SO_OE_N)
    else $error("output driven during hold");
  busy_span_a: assert property ($fell(STATUS[0]) |->
    busy_q >= WRITE_CYCLES - 20'h2 && busy_q <= WRITE_CYCLES + 20'h2)
    else $error("busy length wrong");
  busy_wel_a: assert property ($fell(STATUS[0]) |-> !STATUS[1])
    else $error("latch kept after cycle");
  busy_start_a: assert property ($rose(STATUS[0]) |-> CS_N && $past(STATUS[1]))
    else $error("cycle started without deselect or latch");
  wel_set_a: assert property ($rose(STATUS[1]) |-> CS_N)
    else $error("latch set while selected");
  zero_bit_a: assert property (!STATUS[5])
    else $error("status bit 5 set");
  lock_keep_a: assert property (STATUS[4] |=> STATUS[4])
    else $error("page lock cleared");
  wp_guard_a: assert property ($changed({STATUS[7], STATUS[4:2]}) && $past(STATUS[7])
    |-> $past(WP_N, 8))
    else $error("status written while pin protected");
  cover property ($rose(STATUS[0]));
  cover property (!HOLD_N && !CS_N);
  cover property ($fell(SO_OE_N));
endmodule // see_engine_sva

bind see_engine see_engine_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_see_engine_sva (
  .SYS_CLK(SYS_CLK), .RST(RST), .CS_N(CS_N), .HOLD_N(HOLD_N), .WP_N(WP_N),
  .SO_OE_N(SO_OE_N), .STATUS(STATUS));

// >>> tb/see_host.sv
// Serial host model driving select, clock and data
`timescale 1ns/100ps
module see_host
(
  // System
  input wire clk,
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire so
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One session, MSB first; clock idles at m3 (mode 3 high)
  task automatic xfer(input int n, input logic [63:0] tx, input bit m3, input int hb,
    output logic [63:0] rx);
    rx = 64'h0;
    sck = m3;
    tick(4);
    cs_n = 1'b0;
    tick(8);
    for (int i = n - 1; i >= 0; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      if (i == hb)
      begin
        tick(4);
        hold_n = 1'b0;
        si = ~si;
        tick(12);
        si = tx[i];
        hold_n = 1'b1;
      end
      tick(8);
      sck = 1'b1;
      rx = {rx[62:0], so};
      tick(8);
    end
    sck = m3;
    tick(8);
    cs_n = 1'b1;
    // Released line must not look valid
    si = ~si;
    tick(24);
  endtask
endmodule // see_host

// >>> tb/test_see_engine.sv
// Self-checking bench for the serial EEPROM engine
`timescale 1ns/100ps
module test_see_engine;
  localparam [19:0] WCYC = 20'h4b0;
  logic sys_clk;
  logic rst;
  logic wp_n;
  wire cs_n;
  wire sck;
  wire si;
  wire hold_n;
  wire so;
  wire so_oe_n;
  wire so_w;
  wire [7:0] status;
  logic [63:0] rx;
  bit m3;
  int n_errors;
  int checks;
  // Nobody else drives the pin, so it floats when released
  assign so_w = so_oe_n ? 1'bz : so;
  see_engine #(.WRITE_CYCLES(WCYC)) i_see_engine (.SYS_CLK(sys_clk), .RST(rst),
    .CS_N(cs_n), .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n), .SO(so),
    .SO_OE_N(so_oe_n), .STATUS(status));
  see_host i_see_host (.clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so(so_w));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic ses(input int n, input logic [63:0] tx, input int hb = -1);
    i_see_host.xfer(n, tx, m3, hb, rx);
  endtask
  task automatic ready();
    int k;
    ses(16, 64'h0500);
    for (k = 0; k < 20 && rx[0] !== 1'b0; k++)
      ses(16, 64'h0500);
    if (k == 20)
    begin
      chk("ready", 64'h0, rx[0]);
      results();
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    ses(8, 64'h06);
    ses(40, {24'h0, 8'h02, a, d});
  endtask
  task automatic sw(input logic [7:0] d);
    ses(8, 64'h06);
    ses(16, {48'h0, 8'h01, d});
    ready();
  endtask
  task automatic t_latch();
    chk("status", 8'h00, status);
    chk("oe", 1'b1, so_oe_n);
    ses(8, 64'h06);
    chk("wel set", 8'h02, status);
    ses(8, 64'h04);
    chk("wel clr", 8'h00, status);
    ses(9, 64'h0c);
    chk("extra clk", 8'h00, status);
    ses(16, 64'hff00);
    chk("unknown op", 16'hzzzz, rx[15:0]);
  endtask
  task automatic t_write();
    ses(8, 64'h06);
    ses(56, {8'h0, 8'h02, 24'hfffffe, 24'ha1b2c3});
    chk("busy", 8'h03, status);
    ses(16, 64'h0500);
    chk("status busy", 8'h03, rx[7:0]);
    ses(40, {24'h0, 8'h03, 24'h01fffe, 8'h0});
    chk("read busy", 8'hzz, rx[7:0]);
    ready();
    chk("wel end", 8'h00, status);
    wr(24'h000000, 8'hd4);
    ready();
    m3 = 1'b1;
    ses(56, {8'h0, 8'h03, 24'h01fffe, 24'h0});
    chk("read wrap", 24'ha1b2d4, rx[23:0]);
    ses(40, {24'h0, 8'h03, 24'h01ff00, 8'h0});
    chk("page wrap", 8'hc3, rx[7:0]);
    m3 = 1'b0;
  endtask
  task automatic t_refuse();
    ses(40, {24'h0, 8'h02, 24'h000010, 8'h55});
    chk("no wel", 8'h00, status);
    ses(8, 64'h06);
    ses(43, {21'h0, 8'h02, 24'h000010, 8'h55, 3'h0});
    chk("partial", 8'h02, status);
    ses(8, 64'h04);
  endtask
  task automatic t_status();
    ses(8, 64'h06);
    ses(16, 64'h01ff);
    chk("sw busy", 8'h8f, status);
    ready();
    chk("sw done", 8'h8c, status);
    wr(24'h000020, 8'h66);
    chk("full protect", 8'h8e, status);
    wp_n = 1'b0;
    ses(16, 64'h0100);
    chk("pin protect", 8'h8e, status);
    wp_n = 1'b1;
    ses(16, 64'h0100);
    ready();
    chk("pin high", 8'h00, status);
    wp_n = 1'b0;
    sw(8'h04);
    chk("pin off", 8'h04, status);
    wp_n = 1'b1;
    ses(8, 64'h06);
    fork
      ses(16, 64'h0108);
      begin
        repeat (200) @(posedge sys_clk);
        #1;
        wp_n = 1'b0;
      end
    join
    chk("wp abort", 8'h06, status);
    wp_n = 1'b1;
    ses(8, 64'h04);
    sw(8'h00);
  endtask
  task automatic t_idpage();
    sw(8'h40);
    chk("page sel", 8'h40, status);
    wr(24'hffff10, 8'h5a);
    ready();
    chk("sel clr", 8'h00, status);
    sw(8'h40);
    ses(40, {24'h0, 8'h03, 24'h000010, 8'h0}, 3);
    chk("id read", 8'h5a, rx[7:0]);
    sw(8'h10);
    sw(8'h40);
    wr(24'h000010, 8'ha5);
    chk("locked", 1'b0, status[0]);
  endtask
  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    m3 = 1'b0;
    n_errors = 0;
    checks = 0;
    rx = 64'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    t_latch();
    t_write();
    t_refuse();
    t_status();
    t_idpage();
    results();
  end
endmodule // test_see_engine
